// >>> logic/rx_field_mux.sv
// receive output field multiplexer: upper shared pins, low command pins, command flag
// assumes decoded or raw characters arrive on the interface clock, config over ahb-lite
//
// Functional notes
// R01: narrow decoded: upper pins carry command bits 3:2
// R02: wide decoded: upper pins carry data bits 9:8
// R03: decoder bypassed: upper pins carry raw bits 9:8
// R04: upper pins update on interface clock rising edge
// R05: decoded: low pins carry command bits 1:0
// R06: narrow bypassed: low pins driven low
// R07: wide bypassed: low pins carry raw bits 11:10
// R08: low pins update on interface clock rising edge
// R09: output enable three-states all these pins
// R10: fifo bypassed: interface clock pin outputs recovered clock
// R11: selected when enable follows chip select low
// R12: enable polarity follows external fifo select
// R13: narrow decoded: flag high marks new command
//
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module rx_field_mux (
  input  wire logic                            mclk_i,
  input  wire logic                            rstn_i,
  input  wire logic                            hsel_i,
  input  wire logic [31:0]                     haddr_i,
  input  wire logic [1:0]                      htrans_i,
  input  wire logic                            hwrite_i,
  input  wire logic [2:0]                      hsize_i,
  input  wire logic [31:0]                     hwdata_i,
  input  wire logic                            hready_i,
  output logic      [31:0]                     hrdata_o,
  output logic                                 hreadyout_o,
  output logic                                 hresp_o,
  input  wire logic                            link_clk_i,
  input  wire logic                            recovered_clk_i,
  input  wire logic                            char_valid_i,
  input  wire logic                            char_is_command_i,
  input  wire logic [rx_field_pkg::CHAR_W-1:0] char_i,
  input  wire logic                            chip_select_n_i,
  input  wire logic                            rx_output_enable_i,
  output logic                                 rx_interface_clock_o,
  output logic                                 rx_interface_clock_oe_o,
  output logic      [1:0]                      rx_upper_o,
  output logic                                 rx_upper_oe_o,
  output logic      [1:0]                      rx_command_field_o,
  output logic                                 rx_command_field_oe_o,
  output logic                                 rx_command_flag_o,
  output logic                                 rx_command_flag_oe_o
);

  logic [rx_field_pkg::CFG_W-1:0]  cfg;
  logic [rx_field_pkg::ST_W-1:0]   link_status;
  logic [rx_field_pkg::CFG_W-1:0]  cfg_meta_reg;
  logic [rx_field_pkg::CFG_W-1:0]  cfg_link_reg;
  logic                            link_rst_meta_reg;
  logic                            link_rstn_reg;
  logic                            narrow;
  logic                            decode_on;
  logic                            enable_active;
  logic [rx_field_pkg::CMD_W-1:0]  cmd_reg;
  logic [rx_field_pkg::CMD_W-1:0]  cmd_next;
  logic [1:0]                      data_hi_reg;
  logic [1:0]                      data_hi_next;
  logic [rx_field_pkg::CHAR_W-1:0] raw_reg;
  logic [rx_field_pkg::CHAR_W-1:0] raw_next;
  logic [1:0]                      upper_reg;
  logic [1:0]                      low_reg;
  logic                            flag_reg;
  logic                            flag_next;
  logic                            cs_low_reg;
  rx_field_pkg::sel_state_type     sel_state_reg;
  rx_field_pkg::sel_state_type     sel_state_next;

  // enable pin level that means asserted, for either polarity
  function automatic logic enable_level(input logic ext_sel, input logic pin);
    return ext_sel ? pin : !pin;
  endfunction

  rx_field_regs u_regs (
    .mclk_i        (mclk_i),
    .rstn_i        (rstn_i),
    .hsel_i        (hsel_i),
    .haddr_i       (haddr_i),
    .htrans_i      (htrans_i),
    .hwrite_i      (hwrite_i),
    .hsize_i       (hsize_i),
    .hwdata_i      (hwdata_i),
    .hready_i      (hready_i),
    .hrdata_o      (hrdata_o),
    .hreadyout_o   (hreadyout_o),
    .hresp_o       (hresp_o),
    .link_status_i (link_status),
    .cfg_o         (cfg)
  );

  // recovered clock leaves on the interface clock pin only while the fifo is bypassed
  assign rx_interface_clock_o    = recovered_clk_i; // see R10
  assign rx_interface_clock_oe_o = !cfg[rx_field_pkg::CFG_FIFON_BIT]; // see R10

  // reset asserts at once and releases on the link clock
  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link_rst_meta_reg <= 1'b0;
      link_rstn_reg     <= 1'b0;
    end else begin
      link_rst_meta_reg <= 1'b1;
      link_rstn_reg     <= link_rst_meta_reg;
    end
  end

  // config is static in normal use; each bit is a level crossing on its own
  always_ff @(posedge link_clk_i or negedge link_rstn_reg) begin
    if (!link_rstn_reg) begin
      cfg_meta_reg <= rx_field_pkg::CFG_RESET;
      cfg_link_reg <= rx_field_pkg::CFG_RESET;
    end else begin
      cfg_meta_reg <= cfg;
      cfg_link_reg <= cfg_meta_reg;
    end
  end

  assign narrow    = cfg_link_reg[rx_field_pkg::CFG_WIDTH_BIT];
  assign decode_on = cfg_link_reg[rx_field_pkg::CFG_DECN_BIT];

  // command and data groups keep their last values independently
  always_comb begin
    cmd_next     = cmd_reg;
    data_hi_next = data_hi_reg;
    raw_next     = raw_reg;
    flag_next    = flag_reg;
    if (char_valid_i) begin
      if (decode_on) begin
        flag_next = char_is_command_i; // see R13
        if (char_is_command_i) begin
          cmd_next = char_i[rx_field_pkg::CMD_W-1:0];
        end else begin
          data_hi_next = char_i[rx_field_pkg::UPPER_LSB +: 2];
        end
      end else begin
        raw_next  = char_i;
        flag_next = 1'b0;
      end
    end
  end

  always_ff @(posedge link_clk_i or negedge link_rstn_reg) begin
    if (!link_rstn_reg) begin
      cmd_reg     <= '0;
      data_hi_reg <= 2'h0;
      raw_reg     <= '0;
      flag_reg    <= 1'b0;
    end else begin
      cmd_reg     <= cmd_next;
      data_hi_reg <= data_hi_next;
      raw_reg     <= raw_next;
      flag_reg    <= flag_next;
    end
  end

  // pins change only on the interface clock, whichever end drives it
  always_ff @(posedge link_clk_i or negedge link_rstn_reg) begin
    if (!link_rstn_reg) begin
      upper_reg <= 2'h0;
    end else if (!decode_on) begin
      upper_reg <= raw_next[rx_field_pkg::UPPER_LSB +: 2]; // see R03, R04
    end else if (narrow) begin
      upper_reg <= cmd_next[3:2]; // see R01, R04
    end else begin
      upper_reg <= data_hi_next; // see R02, R04
    end
  end

  always_ff @(posedge link_clk_i or negedge link_rstn_reg) begin
    if (!link_rstn_reg) begin
      low_reg <= 2'h0;
    end else if (decode_on) begin
      low_reg <= cmd_next[1:0]; // see R05, R08
    end else if (narrow) begin
      low_reg <= 2'h0; // see R06, R08
    end else begin
      low_reg <= raw_next[rx_field_pkg::LOW_EXT_LSB +: 2]; // see R07, R08
    end
  end

  // enable and chip select are synchronous to the interface clock itself
  assign enable_active = enable_level(cfg_link_reg[rx_field_pkg::CFG_EXT_BIT],
                                      rx_output_enable_i); // see R12

  always_ff @(posedge link_clk_i or negedge link_rstn_reg) begin
    if (!link_rstn_reg) begin
      cs_low_reg <= 1'b0;
    end else begin
      cs_low_reg <= !chip_select_n_i;
    end
  end

  always_comb begin
    sel_state_next = sel_state_reg;
    unique case (sel_state_reg)
      rx_field_pkg::SEL_IDLE: begin
        if (enable_active && cs_low_reg) begin
          sel_state_next = rx_field_pkg::SEL_ACTIVE; // see R11
        end
      end
      rx_field_pkg::SEL_ACTIVE: begin
        if (!enable_active) begin
          sel_state_next = rx_field_pkg::SEL_IDLE; // see R09
        end
      end
    endcase
  end

  always_ff @(posedge link_clk_i or negedge link_rstn_reg) begin
    if (!link_rstn_reg) begin
      sel_state_reg <= rx_field_pkg::SEL_IDLE;
    end else begin
      sel_state_reg <= sel_state_next;
    end
  end

  assign rx_upper_o            = upper_reg;
  assign rx_command_field_o    = low_reg;
  assign rx_command_flag_o     = flag_reg;
  // one registered select drives all three enables, so they turn together
  assign rx_upper_oe_o         = (sel_state_reg == rx_field_pkg::SEL_ACTIVE); // see R09
  assign rx_command_field_oe_o = rx_upper_oe_o; // see R09
  assign rx_command_flag_oe_o  = rx_upper_oe_o; // see R09

  assign link_status = {rx_upper_oe_o, flag_reg, low_reg, upper_reg};

  // checks on the interface clock side, except the clock pin direction check on mclk_i
  AST_NARROW_CMD_UPPER: assert property ( // see R01
    @(posedge link_clk_i) disable iff (!link_rstn_reg)
    char_valid_i && char_is_command_i && decode_on && narrow
    |=> rx_upper_o == $past(char_i[3:2])
  ) else $error("upper pins do not carry command bits 3:2");

  AST_WIDE_DATA_UPPER: assert property ( // see R02
    @(posedge link_clk_i) disable iff (!link_rstn_reg)
    char_valid_i && !char_is_command_i && decode_on && !narrow
    |=> rx_upper_o == $past(char_i[9:8])
  ) else $error("upper pins do not carry data bits 9:8");

  AST_BYPASS_UPPER: assert property ( // see R03
    @(posedge link_clk_i) disable iff (!link_rstn_reg)
    char_valid_i && !decode_on |=> rx_upper_o == $past(char_i[9:8])
  ) else $error("upper pins do not carry raw bits 9:8");

  AST_PINS_HOLD: assert property ( // see R04
    @(posedge link_clk_i) disable iff (!link_rstn_reg)
    !char_valid_i && $stable(cfg_link_reg)
    |=> $stable(rx_upper_o) && $stable(rx_command_field_o)
  ) else $error("output pins changed with no new character");

  AST_DECODED_LOW: assert property ( // see R05
    @(posedge link_clk_i) disable iff (!link_rstn_reg)
    char_valid_i && char_is_command_i && decode_on
    |=> rx_command_field_o == $past(char_i[1:0])
  ) else $error("low pins do not carry command bits 1:0");

  AST_NARROW_BYPASS_LOW: assert property ( // see R06
    @(posedge link_clk_i) disable iff (!link_rstn_reg)
    !decode_on && narrow |=> rx_command_field_o == 2'h0
  ) else $error("low pins not low in narrow bypass");

  AST_WIDE_BYPASS_LOW: assert property ( // see R07
    @(posedge link_clk_i) disable iff (!link_rstn_reg)
    char_valid_i && !decode_on && !narrow
    |=> rx_command_field_o == $past(char_i[11:10])
  ) else $error("low pins do not carry raw bits 11:10");

  AST_CMD_KEEPS_DATA: assert property ( // see R08
    @(posedge link_clk_i) disable iff (!link_rstn_reg)
    char_valid_i && !char_is_command_i && decode_on && $stable(cfg_link_reg)
    |=> $stable(rx_command_field_o)
  ) else $error("low pins moved on a data character");

  AST_SELECT: assert property ( // see R11
    @(posedge link_clk_i) disable iff (!link_rstn_reg)
    !chip_select_n_i ##1 enable_active |=> rx_upper_oe_o && rx_command_flag_oe_o
  ) else $error("pins not driven after selection");

  AST_DESELECT: assert property ( // see R09
    @(posedge link_clk_i) disable iff (!link_rstn_reg)
    !enable_active |=> !rx_upper_oe_o && !rx_command_field_oe_o && !rx_command_flag_oe_o
  ) else $error("pins still driven after enable went away");

  AST_POLARITY: assert property ( // see R12
    @(posedge link_clk_i) disable iff (!link_rstn_reg)
    $stable(cfg_link_reg) && cfg_link_reg[rx_field_pkg::CFG_EXT_BIT] && !rx_output_enable_i
    |=> !rx_upper_oe_o
  ) else $error("high-active enable taken as asserted while low");

  AST_FLAG: assert property ( // see R13
    @(posedge link_clk_i) disable iff (!link_rstn_reg)
    char_valid_i && decode_on |=> rx_command_flag_o == $past(char_is_command_i)
  ) else $error("command flag does not mark the character kind");

  AST_CLOCK_OUT: assert property ( // see R10
    @(posedge mclk_i) disable iff (!rstn_i)
    rx_interface_clock_oe_o == !cfg[rx_field_pkg::CFG_FIFON_BIT]
  ) else $error("interface clock pin direction wrong");

  COV_SELECTED: cover property (
    @(posedge link_clk_i) disable iff (!link_rstn_reg)
    !chip_select_n_i ##1 enable_active ##1 rx_upper_oe_o
  );

  COV_NARROW_CMD: cover property (
    @(posedge link_clk_i) disable iff (!link_rstn_reg)
    char_valid_i && char_is_command_i && decode_on && narrow ##1 rx_command_flag_o
  );

  COV_WIDE_BYPASS: cover property (
    @(posedge link_clk_i) disable iff (!link_rstn_reg)
    char_valid_i && !decode_on && !narrow ##1 rx_command_field_o != 2'h0
  );

  COV_FIFO_BYPASS: cover property (
    @(posedge mclk_i) disable iff (!rstn_i)
    rx_interface_clock_oe_o
  );

endmodule

`default_nettype wire

// >>> inc/rx_field_pkg.sv
// constants, field layout and types for the receive output field multiplexer
// assumes a 32-bit ahb-lite register bus and a 12-bit received character path
package rx_field_pkg;

  // character path
  localparam int CHAR_W = 12;
  localparam int UPPER_LSB = 8;
  localparam int LOW_EXT_LSB = 10;
  localparam int CMD_W = 4;

  // register byte offsets, decoded on the low address bits
  localparam int OFS_W = 4;
  localparam logic [OFS_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [OFS_W-1:0] STATUS_OFS = 4'h4;

  // control register fields
  localparam int CFG_W = 4;
  localparam int CFG_WIDTH_BIT = 0;
  localparam int CFG_DECN_BIT = 1;
  localparam int CFG_FIFON_BIT = 2;
  localparam int CFG_EXT_BIT = 3;
  // decoder and fifo in use, wide characters, active-low enable
  localparam logic [CFG_W-1:0] CFG_RESET = 4'h6;

  // status register fields
  localparam int ST_W = 6;
  localparam int ST_UPPER_LSB = 0;
  localparam int ST_LOW_LSB = 2;
  localparam int ST_FLAG_BIT = 4;
  localparam int ST_SEL_BIT = 5;
  localparam logic [ST_W-1:0] ST_RESET = 6'h00;

  // ahb-lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic {
    SEL_IDLE,
    SEL_ACTIVE
  } sel_state_type;

endpackage

// >>> logic/rx_field_regs.sv
// ahb-lite register slave for the receive field multiplexer
// assumes one master, zero-wait answers, status bits arriving from the link clock domain
`timescale 1ns/100ps
`default_nettype none

module rx_field_regs (
  input  wire logic                           mclk_i,
  input  wire logic                           rstn_i,
  input  wire logic                           hsel_i,
  input  wire logic [31:0]                    haddr_i,
  input  wire logic [1:0]                     htrans_i,
  input  wire logic                           hwrite_i,
  input  wire logic [2:0]                     hsize_i,
  input  wire logic [31:0]                    hwdata_i,
  input  wire logic                           hready_i,
  output logic      [31:0]                    hrdata_o,
  output logic                                hreadyout_o,
  output logic                                hresp_o,
  input  wire logic [rx_field_pkg::ST_W-1:0]  link_status_i,
  output logic      [rx_field_pkg::CFG_W-1:0] cfg_o
);

  logic                            wr_pend_reg;
  logic [rx_field_pkg::OFS_W-1:0]  addr_reg;
  logic [rx_field_pkg::ST_W-1:0]   status_meta_reg;
  logic [rx_field_pkg::ST_W-1:0]   status_reg;
  logic [rx_field_pkg::CFG_W-1:0]  cfg_reg;
  logic                            take;

  // only whole-word transfers are acted on; others complete with no effect
  assign take = hsel_i && hready_i && (htrans_i == rx_field_pkg::HTRANS_NONSEQ)
                && (hsize_i == rx_field_pkg::HSIZE_WORD);

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_pend_reg <= 1'b0;
      addr_reg    <= '0;
    end else if (hready_i) begin
      wr_pend_reg <= take && hwrite_i;
      addr_reg    <= haddr_i[rx_field_pkg::OFS_W-1:0];
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_reg <= rx_field_pkg::CFG_RESET;
    end else if (wr_pend_reg && addr_reg == rx_field_pkg::CTRL_OFS) begin
      cfg_reg <= hwdata_i[rx_field_pkg::CFG_W-1:0];
    end
  end

  // status is a set of slow levels; bits may skew by a cycle against each other
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status_meta_reg <= rx_field_pkg::ST_RESET;
      status_reg      <= rx_field_pkg::ST_RESET;
    end else begin
      status_meta_reg <= link_status_i;
      status_reg      <= status_meta_reg;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (take && !hwrite_i) begin
      unique case (haddr_i[rx_field_pkg::OFS_W-1:0])
        rx_field_pkg::CTRL_OFS:   hrdata_o <= {28'h000_0000, cfg_reg};
        rx_field_pkg::STATUS_OFS: hrdata_o <= {26'h000_0000, status_reg};
        default:                  hrdata_o <= 32'h0000_0000;
      endcase
    end
  end

  assign hreadyout_o = 1'b1;
  assign hresp_o     = rx_field_pkg::HRESP_OKAY;
  assign cfg_o       = cfg_reg;

endmodule

`default_nettype wire

// >>> testbench/rx_host_model.sv
// host side of the receive output pins: interface clock, chip select, receive enable
// assumes the device samples chip select and enable on the rising interface clock
`timescale 1ns/100ps
`default_nettype none

module rx_host_model (
  input  wire logic       link_clk_i,
  input  wire logic       active_high_i,
  input  wire logic [1:0] upper_i,
  input  wire logic       upper_oe_i,
  output logic            host_clk_o,
  output logic            chip_select_n_o,
  output logic            enable_o,
  output logic [1:0]      upper_wire_o
);
  logic       en_act;
  logic [1:0] last_upper;

  initial begin
    host_clk_o = 1'b0;
    chip_select_n_o = 1'b1;
    en_act = 1'b0;
    last_upper = 2'h0;
    #7;
    forever #32 host_clk_o = ~host_clk_o;
  end

  // level follows the polarity choice so an inactive request stays inactive on a flip
  assign enable_o = active_high_i ? en_act : ~en_act;

  // a released pin keeps no value: show the inverse so a stale read cannot match
  always @(posedge link_clk_i) begin
    if (upper_oe_i) begin
      last_upper <= upper_i;
    end
  end
  assign upper_wire_o = upper_oe_i ? upper_i : ~last_upper;

  task automatic select();
    @(posedge link_clk_i);
    chip_select_n_o <= 1'b0;
    @(posedge link_clk_i);
    chip_select_n_o <= 1'b1;
    en_act <= 1'b1;
  endtask

  // enable without a preceding chip select must not select the device
  task automatic enable_only();
    @(posedge link_clk_i);
    en_act <= 1'b1;
  endtask

  task automatic release_bus();
    @(posedge link_clk_i);
    en_act <= 1'b0;
  endtask

endmodule

`default_nettype wire

// >>> testbench/receive_output_field_mux_tb.sv
// self-checking bench for the receive output field multiplexer
// assumes zero-wait ahb-lite slave and a 64 ns interface clock from host or recovered source
`timescale 1ns/100ps
`default_nettype none

module receive_output_field_mux_tb;
  logic        mclk, rstn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, r;
  logic [1:0]  htrans, upper, low, upper_wire;
  logic [2:0]  hsize;
  logic        rec_clk, host_clk, link_clk, char_valid, char_cmd, cs_n, en;
  logic        ifclk, ifclk_oe, upper_oe, low_oe, flag, flag_oe;
  logic [11:0] char_v;
  logic        w, dn, fifon, ext;
  logic [3:0]  cmd_q;
  logic [9:0]  data_q;
  logic [4:0]  last_exp;
  logic [4:0]  exp_q[$];
  int          err_count, tests_run, seed, cycles;

  assign link_clk = fifon ? host_clk : rec_clk;

  rx_field_mux dut_u (.mclk_i(mclk), .rstn_i(rstn), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .link_clk_i(link_clk), .recovered_clk_i(rec_clk), .char_valid_i(char_valid),
    .char_is_command_i(char_cmd), .char_i(char_v), .chip_select_n_i(cs_n),
    .rx_output_enable_i(en), .rx_interface_clock_o(ifclk), .rx_interface_clock_oe_o(ifclk_oe),
    .rx_upper_o(upper), .rx_upper_oe_o(upper_oe), .rx_command_field_o(low),
    .rx_command_field_oe_o(low_oe), .rx_command_flag_o(flag), .rx_command_flag_oe_o(flag_oe));

  rx_host_model host_u (.link_clk_i(link_clk), .active_high_i(ext), .upper_i(upper),
    .upper_oe_i(upper_oe), .host_clk_o(host_clk), .chip_select_n_o(cs_n), .enable_o(en),
    .upper_wire_o(upper_wire));

  always #25 mclk = ~mclk;

  initial begin
    rec_clk = 1'b0;
    #19;
    forever #32 rec_clk = ~rec_clk;
  end

  task automatic summarize();
    $display("mismatches %0d of %0d comparisons", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_pin(input logic [4:0] got, input logic [4:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t pins %h expected %h", $time, got, exp);
    end
  endtask

  // one single word transfer; waits on hready, never on a fixed count
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= rx_field_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= rx_field_pkg::HSIZE_WORD;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    q = hrdata;
  endtask

  // config crosses into the link domain, so let it settle before traffic
  task automatic set_cfg(input logic [3:0] c);
    ahb(1'b1, 32'h0, {28'h0, c}, rd);
    w = c[0];
    dn = c[1];
    fifon = c[2];
    ext = c[3];
    repeat (8) @(posedge link_clk);
  endtask

  task automatic send(input logic c, input logic [11:0] ch);
    @(posedge link_clk);
    char_valid <= 1'b1;
    char_cmd <= c;
    char_v <= ch;
    if (dn) begin
      if (c) cmd_q = ch[3:0];
      else data_q = ch[9:0];
      last_exp = {w ? cmd_q[3:2] : data_q[9:8], cmd_q[1:0], c};
    end else begin
      last_exp = {ch[9:8], w ? 2'b00 : ch[11:10], 1'b0};
    end
    exp_q.push_back(last_exp);
  endtask

  task automatic burst(input int n);
    for (int i = 0; i < n; i++) begin
      r = $random(seed);
      send(dn & r[12], r[11:0]);
    end
    @(posedge link_clk);
    char_valid <= 1'b0;
    repeat (3) @(posedge link_clk);
  endtask

  always @(posedge link_clk) begin : mon
    logic got;
    got = char_valid;
    #1;
    if (got === 1'b1 && exp_q.size() > 0) begin
      cmp_pin({upper, low, flag}, exp_q.pop_front());
    end
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      summarize();
    end
  end

  initial begin
    {mclk, rstn, hsel, hwrite, char_valid, char_cmd, ext} = 7'h0;
    {haddr, hwdata, htrans, hsize, char_v, cmd_q, data_q} = '0;
    {w, dn, fifon} = 3'b011;
    seed = 45;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    repeat (8) @(posedge link_clk);
    ahb(1'b0, 32'h0, 32'h0, rd);
    cmp_reg(rd, {28'h0, rx_field_pkg::CFG_RESET});
    cmp_reg({31'h0, ifclk_oe}, 32'h0);
    cmp_reg({31'h0, hresp}, {31'h0, rx_field_pkg::HRESP_OKAY});
    ahb(1'b0, 32'h4, 32'h0, rd);
    cmp_reg(rd, 32'h0);
    ahb(1'b0, 32'h8, 32'h0, rd);
    cmp_reg(rd, 32'h0);
    r = $random(seed);
    ahb(1'b1, 32'h0, r, rd);
    ahb(1'b0, 32'h0, 32'h0, rd);
    cmp_reg(rd, r & 32'hf);
    // wide/narrow, decoded/bypassed, host clock in use
    for (int m = 0; m < 4; m++) begin
      set_cfg({2'b01, ~m[1], m[0]});
      if (dn) send(1'b1, 12'(r));
      burst(8);
    end
    set_cfg(4'h6);
    host_u.enable_only();
    repeat (2) @(posedge link_clk);
    #1;
    cmp_pin({2'h0, upper_oe, low_oe, flag_oe}, 5'h00);
    host_u.release_bus();
    for (int p = 0; p < 2; p++) begin
      set_cfg({p[0], 3'h6});
      host_u.select();
      @(posedge link_clk);
      #1;
      cmp_pin({2'h0, upper_oe, low_oe, flag_oe}, 5'h07);
      cmp_pin({3'h0, upper_wire}, {3'h0, upper});
      host_u.release_bus();
      @(posedge link_clk);
      #1;
      cmp_pin({2'h0, upper_oe, low_oe, flag_oe}, 5'h00);
    end
    // fifo bypassed: link logic now runs on the recovered clock
    set_cfg(4'h0);
    cmp_reg({31'h0, ifclk_oe}, 32'h1);
    repeat (3) begin
      #11;
      cmp_pin({4'h0, ifclk}, {4'h0, rec_clk});
    end
    burst(5);
    ahb(1'b0, 32'h4, 32'h0, rd);
    // status packs flag above the low pins, and the low pins above the upper pins
    cmp_reg(rd & 32'h1f, {27'h0, last_exp[0], last_exp[2:1], last_exp[4:3]});
    summarize();
  end

endmodule

`default_nettype wire
